// >>> inc/irq_wake_pkg.sv
/*
 * constants, register layouts and state codes shared by the pin interrupt and wake block.
 * assumes a 50 MHz aclk and an instruction cycle of four quarter phases.
 */
package irq_wake_pkg;

	localparam int CLK_PERIOD_NS    = 20;
	localparam int TCY_NS           = 80;
	localparam int CLKS_PER_TCY     = TCY_NS / CLK_PERIOD_NS;
	// instruction cycles from the q1 sample to the vector
	localparam int VECTOR_DELAY_TCY = 3;

	localparam int ADDR_LSB = 2;
	localparam int IDX_W    = 6;
	localparam int REG_W    = 8;

	// register indices; byte address is index * 4
	localparam logic [IDX_W-1:0] IDX_IRQ_CONTROL = 6'h0b;
	localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE0 = 6'h0c;
	localparam logic [IDX_W-1:0] IDX_IRQ_STATUS  = 6'h0d;
	localparam logic [IDX_W-1:0] IDX_IRQ_MASK    = 6'h0e;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic       global_irq_enable;
		logic       peripheral_irq_enable;
		logic [4:0] rsvd;
		logic       edge_polarity_select;
	} irq_control_t;

	typedef struct packed {
		logic [6:0] rsvd;
		logic       pin_irq_enable;
	} irq_enable0_t;

	typedef struct packed {
		logic [4:0] rsvd;
		logic       vector_evt;
		logic       wake_evt;
		logic       pin_irq_flag;
	} irq_status_t;

	localparam irq_control_t CTRL_RESET    = 8'h01;
	localparam irq_enable0_t ENABLE0_RESET = 8'h00;
	localparam irq_status_t  STATUS_RESET  = 8'h00;
	localparam irq_status_t  MASK_RESET    = 8'h00;
	localparam irq_status_t  STATUS_USED   = 8'h07;

	typedef enum logic [3:0] {
		Q1 = 4'b0001,
		Q2 = 4'b0010,
		Q3 = 4'b0100,
		Q4 = 4'b1000
	} qphase_t;

	typedef enum logic [3:0] {
		ST_RUN       = 4'b0001,
		ST_LATENCY   = 4'b0010,
		ST_SLEEP     = 4'b0100,
		ST_WAKE_STEP = 4'b1000
	} wake_state_t;

endpackage

// >>> rtl/pin_edge_detect.sv
/*
 * edge detector for the external interrupt pin with selectable polarity.
 * assumes the pin is already synchronous to aclk.
 */
`timescale 1ns/100ps
module pin_edge_detect (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic pin,
	input  wire logic rising_sel,
	output logic      edge_pulse
);
	logic pin_ff;

	// tracks the pin through reset too, so a pin idling high gives no false edge after release
	always_ff @(posedge aclk) begin
		pin_ff <= pin;
	end

	// polarity one: low to high; polarity zero: high to low
	assign edge_pulse = aresetn && (pin != pin_ff) && (pin == rising_sel);

endmodule

// >>> rtl/qphase_gen.sv
/*
 * quarter phase sequencer: four aclk cycles make one instruction cycle.
 * assumes a free running aclk; q1 follows the first edge after reset.
 */
`timescale 1ns/100ps
module qphase_gen
	import irq_wake_pkg::*;
(
	input  wire logic aclk,
	input  wire logic aresetn,
	output logic      q1
);
	qphase_t phase_ff;
	qphase_t nxt_phase;

	always_comb begin
		unique case (phase_ff)
			Q1: nxt_phase = Q2;
			Q2: nxt_phase = Q3;
			Q3: nxt_phase = Q4;
			Q4: nxt_phase = Q1;
			default: nxt_phase = Q1;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			phase_ff <= Q4;
		end else begin
			phase_ff <= nxt_phase;
		end
	end

	assign q1 = (phase_ff == Q1);

endmodule

// >>> rtl/ext_pin_irq_wake.sv
/*
 * external pin interrupt, vectoring and sleep wake logic with an AXI4-Lite register slave.
 * assumes the core reports sleep entry with a one-cycle pulse and acts on the vector pulse.
 */
// Summary of operation
// - an edge on the interrupt pin raises the interrupt request.
// - the pin interrupt reaches the core only while the pin interrupt enable bit is set.
// - polarity select one triggers on a rising edge, zero on a falling edge.
// - the flag is sampled at q1 of every instruction cycle and may be set in any phase.
// - the vector follows within three to five instruction cycles of the edge.
// - a request is accepted only at q1, so latency from acceptance to the vector is one fixed count.
// - on wake the core vectors if global enable is set, else it resumes after sleep.
// - the instruction after sleep always runs before any branch to the service routine.
// - the control register at index 0x0b holds global, peripheral and polarity bits.
`timescale 1ns/100ps
module ext_pin_irq_wake
	import irq_wake_pkg::*;
#(
	parameter int ADDR_W = 8
)
(
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	input  wire logic              int_pin,
	input  wire logic              sleep_cmd,
	output logic                   vector_req,
	output logic                   wake_pulse,
	output logic                   asleep,
	output logic                   irq
);
	localparam int WORD_W = ADDR_W - ADDR_LSB;
	// acceptance is sampled at q1; the vector pulse shows one edge after the last q1 of the wait
	localparam int LAT_LO = VECTOR_DELAY_TCY * CLKS_PER_TCY + 1;
	localparam int LAT_HI = LAT_LO;

	irq_control_t      ctl_ff;
	irq_control_t      nxt_ctl;
	irq_enable0_t      en0_ff;
	irq_status_t       status_ff;
	irq_status_t       nxt_status;
	irq_status_t       mask_ff;
	wake_state_t       state_ff;
	wake_state_t       nxt_state;
	logic [1:0]        lat_cnt_ff;
	logic [1:0]        nxt_lat_cnt;
	logic              vector_ff;
	logic              wake_ff;
	logic              asleep_ff;
	logic              irq_ff;
	logic              awready_ff;
	logic              wready_ff;
	logic              bvalid_ff;
	logic [1:0]        bresp_ff;
	logic              arready_ff;
	logic              rvalid_ff;
	logic [1:0]        rresp_ff;
	logic [31:0]       rdata_ff;
	logic [ADDR_W-1:0] awaddr_ff;
	logic [7:0]        wdata_ff;
	logic              wstrb0_ff;
	logic              edge_pulse;
	logic              q1;

	pin_edge_detect u_edge (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.pin        (int_pin),
		.rising_sel (ctl_ff.edge_polarity_select),
		.edge_pulse (edge_pulse)
	);

	qphase_gen u_qphase (
		.aclk    (aclk),
		.aresetn (aresetn),
		.q1      (q1)
	);

	// ---- register decode ----
	wire [WORD_W-1:0] wr_word  = awaddr_ff[ADDR_W-1:ADDR_LSB];
	wire [WORD_W-1:0] rd_word  = araddr[ADDR_W-1:ADDR_LSB];
	wire              wr_fire  = !awready_ff && !wready_ff && !bvalid_ff;
	wire              wr_ctl   = wr_word == WORD_W'(IDX_IRQ_CONTROL);
	wire              wr_en0   = wr_word == WORD_W'(IDX_IRQ_ENABLE0);
	wire              wr_stat  = wr_word == WORD_W'(IDX_IRQ_STATUS);
	wire              wr_mask  = wr_word == WORD_W'(IDX_IRQ_MASK);
	wire              wr_hit   = wr_ctl || wr_en0 || wr_stat || wr_mask;
	wire              wr_do    = wr_fire && wstrb0_ff;
	wire              rd_ctl   = rd_word == WORD_W'(IDX_IRQ_CONTROL);
	wire              rd_en0   = rd_word == WORD_W'(IDX_IRQ_ENABLE0);
	wire              rd_stat  = rd_word == WORD_W'(IDX_IRQ_STATUS);
	wire              rd_mask  = rd_word == WORD_W'(IDX_IRQ_MASK);
	wire              rd_hit   = rd_ctl || rd_en0 || rd_stat || rd_mask;
	wire [7:0]        rd_byte  = rd_ctl  ? ctl_ff :
	                             rd_en0  ? en0_ff :
	                             rd_stat ? status_ff :
	                             rd_mask ? mask_ff : 8'h00;
	wire [7:0]        w1c      = (wr_do && wr_stat) ? wdata_ff : 8'h00;

	// ---- interrupt request and wake conditions ----
	wire pin_armed   = status_ff.pin_irq_flag && en0_ff.pin_irq_enable;
	wire take_req    = q1 && pin_armed && ctl_ff.global_irq_enable;
	wire lat_done    = q1 && (lat_cnt_ff == 2'(VECTOR_DELAY_TCY - 1));
	// wake needs only the source enable; the clockless source is the software's concern
	wire wake_cond   = q1 && pin_armed;
	wire step_done   = q1;
	wire fire_vector = (state_ff == ST_LATENCY && lat_done) ||
	                   (state_ff == ST_WAKE_STEP && step_done && ctl_ff.global_irq_enable);

	// ---- axi write channel ----
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_ff <= 1'b1;
			awaddr_ff  <= '0;
		end else if (awvalid && awready_ff) begin
			awready_ff <= 1'b0;
			awaddr_ff  <= awaddr;
		end else if (bvalid_ff && bready) begin
			awready_ff <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wready_ff <= 1'b1;
			wdata_ff  <= 8'h00;
			wstrb0_ff <= 1'b0;
		end else if (wvalid && wready_ff) begin
			wready_ff <= 1'b0;
			wdata_ff  <= wdata[7:0];
			wstrb0_ff <= wstrb[0];
		end else if (bvalid_ff && bready) begin
			wready_ff <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_ff <= 1'b1;
			bresp_ff  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	// ---- axi read channel ----
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_ff <= 1'b1;
			rvalid_ff  <= 1'b0;
			rresp_ff   <= RESP_OKAY;
			rdata_ff   <= 32'h0000_0000;
		end else if (arvalid && arready_ff) begin
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b1;
			rresp_ff   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			rdata_ff   <= {24'h00_0000, rd_byte};
		end else if (rvalid_ff && rready) begin
			arready_ff <= 1'b1;
			rvalid_ff  <= 1'b0;
		end
	end

	// ---- control registers ----
	always_comb begin
		nxt_ctl = ctl_ff;
		if (wr_do && wr_ctl) begin
			nxt_ctl = wdata_ff;
		end
		nxt_ctl.rsvd = '0;
		// the core masks further requests until software re-enables
		if (fire_vector) begin
			nxt_ctl.global_irq_enable = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctl_ff  <= CTRL_RESET;
			en0_ff  <= ENABLE0_RESET;
			mask_ff <= MASK_RESET;
		end else begin
			ctl_ff <= nxt_ctl;
			if (wr_do && wr_en0) begin
				en0_ff <= {7'h00, wdata_ff[0]};
			end
			if (wr_do && wr_mask) begin
				mask_ff <= wdata_ff & STATUS_USED;
			end
		end
	end

	// ---- sticky status: an event in the clearing cycle wins ----
	always_comb begin
		nxt_status              = status_ff & ~irq_status_t'(w1c);
		nxt_status.pin_irq_flag = status_ff.pin_irq_flag && !w1c[0] || edge_pulse;
		nxt_status.wake_evt     = nxt_status.wake_evt || (state_ff == ST_SLEEP && wake_cond);
		nxt_status.vector_evt   = nxt_status.vector_evt || fire_vector;
		nxt_status.rsvd         = '0;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_ff <= STATUS_RESET;
			irq_ff    <= 1'b0;
		end else begin
			status_ff <= nxt_status;
			irq_ff    <= |(nxt_status & mask_ff);
		end
	end

	// ---- vectoring and sleep sequencer ----
	always_comb begin
		nxt_state   = state_ff;
		nxt_lat_cnt = lat_cnt_ff;
		unique case (state_ff)
			ST_RUN: begin
				if (take_req) begin
					nxt_state   = ST_LATENCY;
					nxt_lat_cnt = 2'd0;
				end else if (sleep_cmd) begin
					nxt_state = ST_SLEEP;
				end
			end
			ST_LATENCY: begin
				if (lat_done) begin
					nxt_state = ST_RUN;
				end else if (q1) begin
					nxt_lat_cnt = lat_cnt_ff + 2'd1;
				end
			end
			ST_SLEEP: begin
				if (wake_cond) begin
					nxt_state = ST_WAKE_STEP;
				end
			end
			ST_WAKE_STEP: begin
				// one instruction cycle for the instruction after sleep
				if (step_done) begin
					nxt_state = ST_RUN;
				end
			end
			default: nxt_state = ST_RUN;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff   <= ST_RUN;
			lat_cnt_ff <= 2'd0;
			vector_ff  <= 1'b0;
			wake_ff    <= 1'b0;
			asleep_ff  <= 1'b0;
		end else begin
			state_ff   <= nxt_state;
			lat_cnt_ff <= nxt_lat_cnt;
			vector_ff  <= fire_vector;
			wake_ff    <= (state_ff == ST_SLEEP) && wake_cond;
			asleep_ff  <= (nxt_state == ST_SLEEP);
		end
	end

	assign awready    = awready_ff;
	assign wready     = wready_ff;
	assign bvalid     = bvalid_ff;
	assign bresp      = bresp_ff;
	assign arready    = arready_ff;
	assign rvalid     = rvalid_ff;
	assign rresp      = rresp_ff;
	assign rdata      = rdata_ff;
	assign vector_req = vector_ff;
	assign wake_pulse = wake_ff;
	assign asleep     = asleep_ff;
	assign irq        = irq_ff;

	// ---- assertions ----
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_wake_seen;
		wake_ff;
	endsequence

	sequence s_no_vector_one_tcy;
		!vector_ff [*4];
	endsequence

	a_edge_sets_flag: assert property (edge_pulse |=> status_ff.pin_irq_flag)
		else $error("pin edge did not set the flag");
	a_enable_gates_req: assert property (
		(state_ff == ST_RUN && nxt_state == ST_LATENCY) |-> en0_ff.pin_irq_enable)
		else $error("request accepted with pin enable clear");
	a_polarity_edge: assert property (
		edge_pulse |-> (int_pin == ctl_ff.edge_polarity_select) && $past(int_pin) != int_pin)
		else $error("edge detected with wrong polarity");
	a_sample_at_q1: assert property (
		$rose(state_ff == ST_LATENCY) |-> $past(q1))
		else $error("request sampled outside q1");
	a_vector_latency: assert property (
		(state_ff == ST_RUN && nxt_state == ST_LATENCY) |-> ##[LAT_LO:LAT_HI] vector_ff)
		else $error("vector not reached within latency");
	a_flag_sticky: assert property (
		$past(status_ff.pin_irq_flag) && !$past(w1c[0]) |-> status_ff.pin_irq_flag)
		else $error("pin flag dropped without software clear");
	a_wake_resume: assert property (
		(state_ff == ST_WAKE_STEP && q1 && !ctl_ff.global_irq_enable)
		|=> state_ff == ST_RUN && !vector_ff)
		else $error("vector taken on wake with global enable clear");
	a_step_before_isr: assert property (s_wake_seen |-> s_no_vector_one_tcy)
		else $error("vector within the instruction after sleep");
	a_ctl_reserved: assert property (ctl_ff.rsvd == 5'h00)
		else $error("reserved control bits set");

endmodule

// >>> tb/pin_source.sv
/*
 * edge source standing on the external interrupt pin.
 * assumes calls come from a bench process just after a rising aclk edge.
 */
`timescale 1ns/100ps
module pin_source (
	input  wire logic aclk,
	output logic      int_pin
);
	initial int_pin = 1'b0;

	// a level is held for whole aclk periods, the shortest width the block can see
	task automatic drive(input logic lvl, input int hold);
		int i;
		int_pin <= lvl;
		for (i = 0; i < hold; i++) begin
			@(posedge aclk);
		end
	endtask
endmodule

// >>> tb/test_ext_pin_irq_wake.sv
/*
 * self-checking bench for the pin interrupt and wake block, with a register model.
 * assumes pin_source drives the pin and the bench is the only AXI4-Lite master.
 */
`timescale 1ns/100ps
module test_ext_pin_irq_wake;
	import irq_wake_pkg::*;
	localparam logic [7:0] A_CTRL = {IDX_IRQ_CONTROL, 2'b00};
	localparam logic [7:0] A_EN0  = {IDX_IRQ_ENABLE0, 2'b00};
	localparam logic [7:0] A_STAT = {IDX_IRQ_STATUS, 2'b00};
	localparam logic [7:0] A_MASK = {IDX_IRQ_MASK, 2'b00};
	localparam logic [7:0] ALL [5] = '{A_CTRL, A_EN0, A_STAT, A_MASK, 8'h3c};
	// pin change to vector pulse, in aclk cycles, for an asynchronous source
	localparam int LAT_MIN = 3 * CLKS_PER_TCY;
	localparam int LAT_MAX = 5 * CLKS_PER_TCY;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, sleep_cmd, pol;
	logic        awready, wready, bvalid, arready, rvalid, vector_req, wake_pulse, asleep;
	logic        irq, int_pin;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	int          error_cnt, n_checks, seed, m_ctrl, m_en, m_stat, m_mask, i, n, lat;

	pin_source src (.aclk(aclk), .int_pin(int_pin));
	ext_pin_irq_wake #(.ADDR_W(8)) uut (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .int_pin(int_pin), .sleep_cmd(sleep_cmd),
		.vector_req(vector_req), .wake_pulse(wake_pulse), .asleep(asleep), .irq(irq)
	);

	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	function automatic logic [1:0] exp_resp(input logic [7:0] a);
		return (a inside {A_CTRL, A_EN0, A_STAT, A_MASK}) ? RESP_OKAY : RESP_SLVERR;
	endfunction

	function automatic logic [31:0] mdl(input logic [7:0] a);
		case (a)
			A_CTRL: return 32'(m_ctrl);
			A_EN0: return 32'(m_en);
			A_STAT: return 32'(m_stat);
			A_MASK: return 32'(m_mask);
			default: return 32'h0000_0000;
		endcase
	endfunction

	// bready and rready stay high, so every response is taken on the edge it is seen
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int t;
		t = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			t++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && t < 50);
		check(32'(bvalid), 32'h0000_0001);
		check(bresp, exp_resp(a));
		case (a)
			A_CTRL: m_ctrl = d & 32'h0000_00c1;
			A_EN0: m_en = d & 32'h0000_0001;
			A_STAT: m_stat = m_stat & ~d & 32'h0000_0007;
			A_MASK: m_mask = d & 32'h0000_0007;
			default: ;
		endcase
	endtask

	task automatic rd(input logic [7:0] a);
		int t;
		t = 0;
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			t++;
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && t < 50);
		check(32'(rvalid), 32'h0000_0001);
		check(rresp, exp_resp(a));
		check(rdata, mdl(a));
	endtask

	task automatic make_edge(input logic p);
		src.drive(~p, 2);
		src.drive(p, 0);
		if (p === m_ctrl[0]) m_stat = m_stat | 1;
	endtask

	function automatic logic pick(input int w);
		return w ? wake_pulse : vector_req;
	endfunction

	task automatic wait_ev(input int w, input int lim, output int cnt);
		cnt = 0;
		do begin
			@(posedge aclk);
			cnt++;
		end while (pick(w) !== 1'b1 && cnt < lim);
	endtask

	task automatic final_report;
		$display("checks=%0d mismatches=%0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge aclk);
		error_cnt++;
		final_report();
	end

	initial begin
		seed = 32'hd644;
		aresetn = 1'b0;
		{awvalid, wvalid, arvalid, sleep_cmd} = 4'h0;
		{bready, rready} = 2'b11;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0000_0000;
		wstrb = 4'hf;
		error_cnt = 0;
		n_checks = 0;
		m_ctrl = CTRL_RESET;
		{m_en, m_stat, m_mask} = '0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (i = 0; i < 10; i++) begin
			if (i == 5) wr(ALL[4], 32'hffff_ffff);
			rd(ALL[i % 5]);
		end
		$display("test register map done");
		for (i = 0; i < 8; i++) begin
			pol = 1'($random(seed));
			wr(A_CTRL, ($random(seed) & 32'h0000_007e) | pol);
			make_edge(pol);
			repeat (2) @(posedge aclk);
			rd(A_STAT);
			wr(A_MASK, $random(seed));
			@(posedge aclk);
			check(irq, |(m_stat & m_mask));
			wr(A_STAT, 32'h0000_0007);
			make_edge(~pol);
			repeat (2) @(posedge aclk);
			rd(A_STAT);
			check(irq, |(m_stat & m_mask));
		end
		$display("test polarity and flag done");
		wr(A_CTRL, 32'h0000_0081);
		make_edge(1'b1);
		wait_ev(0, 24, n);
		check(n, 24);
		wr(A_STAT, 32'h0000_0007);
		wr(A_EN0, 32'h0000_0001);
		for (i = 0; i < 6; i++) begin
			pol = 1'($random(seed));
			wr(A_CTRL, 32'h0000_0080 | pol);
			repeat ($unsigned($random(seed)) % 4) @(posedge aclk);
			make_edge(pol);
			wait_ev(0, 30, n);
			lat = n - 1;
			check(32'(lat >= LAT_MIN && lat <= LAT_MAX), 32'h0000_0001);
			m_ctrl = m_ctrl & 32'h0000_007f;
			m_stat = m_stat | 4;
			rd(A_CTRL);
			rd(A_STAT);
			wr(A_STAT, 32'h0000_0007);
		end
		$display("test vector latency done");
		for (i = 0; i < 2; i++) begin
			wr(A_STAT, 32'h0000_0007);
			wr(A_EN0, 32'h0000_0001);
			wr(A_CTRL, 32'h0000_0001 | (i << 7));
			sleep_cmd <= 1'b1;
			@(posedge aclk);
			sleep_cmd <= 1'b0;
			@(posedge aclk);
			check(asleep, 1'b1);
			make_edge(1'b1);
			wait_ev(1, 30, n);
			check(pick(1), 1'b1);
			check(asleep, 1'b0);
			m_stat = m_stat | 2;
			wait_ev(0, 12, n);
			check(n, i ? CLKS_PER_TCY : 12);
			if (i) m_ctrl = m_ctrl & 32'h0000_007f;
			if (i) m_stat = m_stat | 4;
			rd(A_STAT);
			rd(A_CTRL);
		end
		$display("test sleep wake done");
		final_report();
	end
endmodule
